//--- hw/lsam_defines.svh
// Offsets, field positions, reset values and timing figures of the limit monitor
`ifndef LSAM_DEFINES_SVH
`define LSAM_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LSAM_OFF_CONFIG_ONE 8'h01
`define LSAM_OFF_MASK_ONE 8'h08
`define LSAM_OFF_MASK_TWO 8'h09
`define LSAM_OFF_MASK_THREE 8'h0a
`define LSAM_OFF_LOCAL_HIGH 8'h0b
`define LSAM_OFF_LOCAL_LOW 8'h0c
`define LSAM_OFF_LOCAL_OVER 8'h0d
`define LSAM_OFF_REMOTE_HIGH 8'h0e
`define LSAM_OFF_REMOTE_LOW 8'h0f
`define LSAM_OFF_REMOTE_OVER 8'h10
`define LSAM_OFF_ONTIME_LIMIT 8'h19
`define LSAM_OFF_LOCAL_VALUE 8'h41
`define LSAM_OFF_REMOTE_VALUE 8'h43
`define LSAM_OFF_STATUS_ONE 8'h4f
`define LSAM_OFF_STATUS_TWO 8'h50
`define LSAM_OFF_STATUS_THREE 8'h51

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LSAM_CFG_MONITOR_BIT 0
`define LSAM_CFG_AVERAGING_BIT 1
`define LSAM_CFG_ALERT_MODE_BIT 3
`define LSAM_ST1_LOCAL_HIGH 7
`define LSAM_ST1_LOCAL_LOW 6
`define LSAM_ST1_REMOTE_HIGH 5
`define LSAM_ST1_REMOTE_LOW 4
`define LSAM_ST1_REMOTE_DIODE 3
`define LSAM_ST2_LOCAL_OVER 7
`define LSAM_ST2_REMOTE_OVER 6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LSAM_RST_CONFIG_ONE 8'h01
`define LSAM_RST_MASK 8'h00
`define LSAM_RST_HIGH_LIMIT 8'h8b
`define LSAM_RST_LOW_LIMIT 8'h54
`define LSAM_RST_OVER_LIMIT 8'h95
`define LSAM_RST_ONTIME_LIMIT 8'hff

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LSAM_CLK_KHZ 40000
`define LSAM_LOCAL_SLOT_MS 11
`define LSAM_REMOTE_SLOT_MS 32
`define LSAM_FAST_SLOT_MS 6
`define LSAM_SLOT_CNT_W 21

`endif

//--- hw/lsam_pkg.sv
// Types shared by the limit monitor
package lsam_pkg;

  // Monitoring sequencer states, one-hot
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_LOCAL = 3'b010,
    SEQ_REMOTE = 3'b100
  } lsam_seq_e;

  // Register request carried from the link domain
  typedef struct packed {
    logic write;
    logic ara;
    logic [7:0] addr;
    logic [7:0] data;
  } lsam_req_s;

endpackage

//--- hw/limit_status_alert_monitor.sv
// Limit comparison, sticky status and alert logic of the temperature monitor
// How it works
// - High, low, overtemp byte limits per channel
// - High limit exceeded when value >= limit
// - Low limit exceeded only when value < limit
// - Cycle starts at power-up, restarts on enable
// - Writing 0 to bit 0 stops cycling
// - Each result stored into its value register
// - Slots of 11 ms local, 32 ms remote; 6 ms each with the averaging bit set
// - Next cycle starts automatically after the period
// - Fan pulses counted independently of conversions
// - Three status registers, 1 means out of limit in status one and two
// - Status bits stay set until cleared
// - Status read clears only bits whose fault ended
// - Alert response clears bits whose fault ended
// - Status three bit 0 shows alert driven
// - Alert pin flags unmasked out-of-limit sources
// - Mask bits keep sources off the alert
// - Masked sources still set their status bits
// - Bit 3 picks latched or comparator alert
// - Codes are offset binary, degrees plus 64
`timescale 1ns/100ps
`include "lsam_defines.svh"

module limit_status_alert_monitor #(
  parameter int unsigned LOCAL_SLOT_CYC = `LSAM_LOCAL_SLOT_MS * `LSAM_CLK_KHZ,
  parameter int unsigned REMOTE_SLOT_CYC = `LSAM_REMOTE_SLOT_MS * `LSAM_CLK_KHZ,
  parameter int unsigned FAST_SLOT_CYC = `LSAM_FAST_SLOT_MS * `LSAM_CLK_KHZ
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Link side, own clock
  input wire logic linkClk,
  input wire logic linkReset_n,
  input wire logic linkReq,
  input wire logic linkWrite,
  input wire logic linkAra,
  input wire logic [7:0] linkAddr,
  input wire logic [7:0] linkWdata,
  output logic [7:0] linkRdata,
  output logic linkAck,
  output logic linkBusy,
  // Converter side
  output logic convStart,
  output logic convRemote,
  input wire logic convDone,
  input wire logic [7:0] convData,
  input wire logic convFault,
  // Pins
  input wire logic fanSpeedPulse,
  output logic [7:0] fanPulseCount,
  output logic overtempSignal,
  output logic alertOut,
  output logic alertOe
);

  // ----------------------------------------------------------------
  // Link domain: request capture and answer
  // ----------------------------------------------------------------
  lsam_pkg::lsam_req_s linkHold_r; // Request held stable during crossing
  logic reqTog_r; // Toggles once per request
  logic [2:0] ackSync_r; // Answer toggle synchroniser plus edge stage
  logic [7:0] linkRdata_r; // Read data towards the link
  logic linkAck_r; // One-cycle answer pulse
  logic ackSeen; // Answer toggle as last seen
  logic ackEdge; // New answer arrived
  logic ackTog_r; // Answer toggle
  logic [7:0] coreRdata_r; // Read byte, stable until next request
  logic [7:0] readMux; // Read data selection
  logic alertOe_r; // Alert pin pulled low

  assign ackSeen = ackSync_r[2];
  assign ackEdge = ackSync_r[1] ^ ackSync_r[2];
  assign linkBusy = reqTog_r ^ ackSeen;
  assign linkRdata = linkRdata_r;
  assign linkAck = linkAck_r;

  // Take a request only while idle
  always_ff @(posedge linkClk) begin
    if (!linkReset_n) begin
      linkHold_r <= '0;
      reqTog_r <= 1'b0;
    end else if ((linkReq || linkAra) && !linkBusy) begin
      linkHold_r <= '{write: linkWrite, ara: linkAra, addr: linkAddr, data: linkWdata};
      reqTog_r <= ~reqTog_r;
    end
  end

  // Synchronise answer toggle, latch the read byte
  always_ff @(posedge linkClk) begin
    if (!linkReset_n) begin
      ackSync_r <= 3'h0;
      linkRdata_r <= 8'h00;
      linkAck_r <= 1'b0;
    end else begin
      ackSync_r <= {ackSync_r[1:0], ackTog_r};
      linkAck_r <= ackEdge;
      if (ackEdge) begin
        linkRdata_r <= coreRdata_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core domain: request crossing
  // ----------------------------------------------------------------
  logic [2:0] reqSync_r; // Request toggle synchroniser plus edge stage
  logic reqEdge; // Request toggle moved
  logic regWr; // Register write this cycle
  logic regRd; // Register read this cycle
  logic araDone; // Alert response completed

  assign reqEdge = reqSync_r[1] ^ reqSync_r[2];
  assign araDone = reqEdge && linkHold_r.ara;
  assign regWr = reqEdge && !linkHold_r.ara && linkHold_r.write;
  assign regRd = reqEdge && !linkHold_r.ara && !linkHold_r.write;

  // Synchronise request toggle, answer with read data
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reqSync_r <= 3'h0;
      ackTog_r <= 1'b0;
      coreRdata_r <= 8'h00;
    end else if (ce) begin
      reqSync_r <= {reqSync_r[1:0], reqTog_r};
      if (reqEdge) begin
        ackTog_r <= ~ackTog_r;
        coreRdata_r <= readMux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] config_one_r; // Monitor enable, averaging, alert mode
  logic [7:0] alert_mask_one_r; // Mask for status one sources
  logic [7:0] alert_mask_two_r; // Mask for status two sources
  logic [7:0] alert_mask_three_r; // Mask for status three sources
  logic [7:0] limit_r [6]; // Local high, low, over, remote high, low, over
  logic [7:0] overtemp_ontime_limit_r; // Stored only
  logic [7:0] localValue_r; // Latest local code
  logic [7:0] remoteValue_r; // Latest remote code
  logic [7:0] status_one_r; // Sticky limit status
  logic [7:0] status_two_r; // Sticky overtemp status

  // Limit registers, one per offset
  genvar gi;
  for (gi = 0; gi < 6; gi++) begin : g_limit
    localparam logic [7:0] OFF = `LSAM_OFF_LOCAL_HIGH + 8'(gi);
    localparam logic [7:0] RST = (gi % 3 == 0) ? `LSAM_RST_HIGH_LIMIT :
                                 (gi % 3 == 1) ? `LSAM_RST_LOW_LIMIT : `LSAM_RST_OVER_LIMIT;
    // Byte-wide limit storage
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        limit_r[gi] <= RST;
      end else if (ce && regWr && linkHold_r.addr == OFF) begin
        limit_r[gi] <= linkHold_r.data;
      end
    end
  end

  // Configuration and mask registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      config_one_r <= `LSAM_RST_CONFIG_ONE;
      alert_mask_one_r <= `LSAM_RST_MASK;
      alert_mask_two_r <= `LSAM_RST_MASK;
      alert_mask_three_r <= `LSAM_RST_MASK;
      overtemp_ontime_limit_r <= `LSAM_RST_ONTIME_LIMIT;
    end else if (ce && regWr) begin
      case (linkHold_r.addr)
        `LSAM_OFF_CONFIG_ONE: config_one_r <= linkHold_r.data;
        `LSAM_OFF_MASK_ONE: alert_mask_one_r <= linkHold_r.data;
        `LSAM_OFF_MASK_TWO: alert_mask_two_r <= linkHold_r.data;
        `LSAM_OFF_MASK_THREE: alert_mask_three_r <= linkHold_r.data;
        `LSAM_OFF_ONTIME_LIMIT: overtemp_ontime_limit_r <= linkHold_r.data;
        default: ;
      endcase
    end
  end

  // Read selection, unmapped offsets read zero
  assign readMux =
    (linkHold_r.addr == `LSAM_OFF_CONFIG_ONE) ? config_one_r :
    (linkHold_r.addr == `LSAM_OFF_MASK_ONE) ? alert_mask_one_r :
    (linkHold_r.addr == `LSAM_OFF_MASK_TWO) ? alert_mask_two_r :
    (linkHold_r.addr == `LSAM_OFF_MASK_THREE) ? alert_mask_three_r :
    (linkHold_r.addr >= `LSAM_OFF_LOCAL_HIGH && linkHold_r.addr <= `LSAM_OFF_REMOTE_OVER) ?
      limit_r[3'(linkHold_r.addr - `LSAM_OFF_LOCAL_HIGH)] :
    (linkHold_r.addr == `LSAM_OFF_ONTIME_LIMIT) ? overtemp_ontime_limit_r :
    (linkHold_r.addr == `LSAM_OFF_LOCAL_VALUE) ? localValue_r :
    (linkHold_r.addr == `LSAM_OFF_REMOTE_VALUE) ? remoteValue_r :
    (linkHold_r.addr == `LSAM_OFF_STATUS_ONE) ? status_one_r :
    (linkHold_r.addr == `LSAM_OFF_STATUS_TWO) ? status_two_r :
    (linkHold_r.addr == `LSAM_OFF_STATUS_THREE) ? {7'h00, alertOe_r} :
    8'h00;

  // ----------------------------------------------------------------
  // Monitoring sequencer
  // ----------------------------------------------------------------
  lsam_pkg::lsam_seq_e seq_r; // Current conversion slot
  lsam_pkg::lsam_seq_e seq_nxt;
  logic [`LSAM_SLOT_CNT_W-1:0] slotCnt_r; // Cycles spent in slot
  logic [`LSAM_SLOT_CNT_W-1:0] slotLast; // Final count of this slot
  logic slotEnd; // Slot time used up
  logic monitorOn; // Monitor enable bit
  logic startPulse_r; // Conversion start towards converter
  logic enableWrite; // Write of 1 to the enable bit

  assign monitorOn = config_one_r[`LSAM_CFG_MONITOR_BIT];
  assign enableWrite = regWr && linkHold_r.addr == `LSAM_OFF_CONFIG_ONE &&
                       linkHold_r.data[`LSAM_CFG_MONITOR_BIT];
  // Averaging bit set shortens every slot to the fast figure
  assign slotLast = config_one_r[`LSAM_CFG_AVERAGING_BIT] ? `LSAM_SLOT_CNT_W'(FAST_SLOT_CYC - 1) :
                    (seq_r == lsam_pkg::SEQ_REMOTE) ? `LSAM_SLOT_CNT_W'(REMOTE_SLOT_CYC - 1) :
                    `LSAM_SLOT_CNT_W'(LOCAL_SLOT_CYC - 1);
  assign slotEnd = slotCnt_r >= slotLast;
  assign convStart = startPulse_r;
  assign convRemote = seq_r == lsam_pkg::SEQ_REMOTE;

  // Next slot selection
  always_comb begin
    seq_nxt = seq_r;
    case (seq_r)
      lsam_pkg::SEQ_IDLE: begin
        if (monitorOn || enableWrite) begin
          seq_nxt = lsam_pkg::SEQ_LOCAL;
        end
      end
      lsam_pkg::SEQ_LOCAL: begin
        if (!monitorOn) begin
          seq_nxt = lsam_pkg::SEQ_IDLE;
        end else if (slotEnd) begin
          seq_nxt = lsam_pkg::SEQ_REMOTE;
        end
      end
      lsam_pkg::SEQ_REMOTE: begin
        if (!monitorOn) begin
          seq_nxt = lsam_pkg::SEQ_IDLE;
        end else if (slotEnd) begin
          seq_nxt = lsam_pkg::SEQ_LOCAL;
        end
      end
      default: seq_nxt = lsam_pkg::SEQ_IDLE;
    endcase
  end

  // Slot state, counter and start pulse
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      seq_r <= lsam_pkg::SEQ_IDLE;
      slotCnt_r <= '0;
      startPulse_r <= 1'b0;
    end else if (ce) begin
      seq_r <= seq_nxt;
      startPulse_r <= (seq_nxt != lsam_pkg::SEQ_IDLE) && (seq_nxt != seq_r);
      slotCnt_r <= (seq_nxt != seq_r) ? '0 : slotCnt_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Limit comparison and sticky status
  // ----------------------------------------------------------------
  logic storeLocal; // Local result arrives
  logic storeRemote; // Remote result arrives
  logic [7:0] cond_one_r; // Present conditions, status one layout
  logic [7:0] cond_two_r; // Present conditions, status two layout
  logic [7:0] cond1Nxt;
  logic [7:0] cond2Nxt;
  logic [7:0] set1;
  logic [7:0] set2;
  logic [7:0] clr1;
  logic [7:0] clr2;
  logic clrEvent; // Register read or alert response
  logic hiHit; // Value at or above high limit
  logic loHit; // Value below low limit
  logic ovHit; // Value at or above overtemp limit
  logic [2:0] limBase; // First limit of the storing channel

  assign storeLocal = convDone && seq_r == lsam_pkg::SEQ_LOCAL;
  assign storeRemote = convDone && seq_r == lsam_pkg::SEQ_REMOTE;
  assign limBase = storeRemote ? 3'h3 : 3'h0;
  // Unsigned compare works directly on offset binary codes
  assign hiHit = convData >= limit_r[limBase];
  assign loHit = convData < limit_r[limBase + 3'h1];
  assign ovHit = convData >= limit_r[limBase + 3'h2];

  assign cond1Nxt = storeLocal ? {hiHit, loHit, cond_one_r[5:0]} :
                    storeRemote ? {cond_one_r[7:6], hiHit, loHit, convFault, cond_one_r[2:0]} :
                    cond_one_r;
  assign cond2Nxt = storeLocal ? {ovHit, cond_two_r[6:0]} :
                    storeRemote ? {cond_two_r[7], ovHit, cond_two_r[5:0]} :
                    cond_two_r;
  // Set comes from the fresh comparison, regardless of mask
  assign set1 = cond1Nxt & {8{storeLocal | storeRemote}};
  assign set2 = cond2Nxt & {8{storeLocal | storeRemote}};
  assign clrEvent = araDone || regRd;
  assign clr1 = (araDone || (regRd && linkHold_r.addr == `LSAM_OFF_STATUS_ONE)) ? ~cond1Nxt : 8'h00;
  assign clr2 = (araDone || (regRd && linkHold_r.addr == `LSAM_OFF_STATUS_TWO)) ? ~cond2Nxt : 8'h00;

  // Value store, conditions and sticky bits; a set beats a clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      localValue_r <= 8'h00;
      remoteValue_r <= 8'h00;
      cond_one_r <= 8'h00;
      cond_two_r <= 8'h00;
      status_one_r <= 8'h00;
      status_two_r <= 8'h00;
    end else if (ce) begin
      if (storeLocal) begin
        localValue_r <= convData;
      end
      if (storeRemote) begin
        remoteValue_r <= convData;
      end
      cond_one_r <= cond1Nxt;
      cond_two_r <= cond2Nxt;
      if (clrEvent || storeLocal || storeRemote) begin
        status_one_r <= ((status_one_r & ~clr1) | set1) & 8'hf8;
        status_two_r <= ((status_two_r & ~clr2) | set2) & 8'hc0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Alert and overtemperature outputs
  // ----------------------------------------------------------------
  logic overtemp_r; // Any overtemp condition present
  logic latchedReq; // Unmasked sticky source
  logic compReq; // Unmasked present condition

  assign latchedReq = |((status_one_r & ~alert_mask_one_r) | (status_two_r & ~alert_mask_two_r));
  assign compReq = |((cond_one_r & ~alert_mask_one_r) | (cond_two_r & ~alert_mask_two_r));
  assign alertOut = 1'b0;
  assign alertOe = alertOe_r;
  assign overtempSignal = overtemp_r;

  // Alert drive follows the selected mode
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      alertOe_r <= 1'b0;
      overtemp_r <= 1'b0;
    end else if (ce) begin
      alertOe_r <= config_one_r[`LSAM_CFG_ALERT_MODE_BIT] ? compReq : latchedReq;
      overtemp_r <= |cond_two_r;
    end
  end

  // ----------------------------------------------------------------
  // Fan pulse counting, free of the conversion sequence
  // ----------------------------------------------------------------
  logic [2:0] fanSync_r; // Synchroniser plus edge stage
  logic [7:0] fanCount_r; // Rising edges seen

  assign fanPulseCount = fanCount_r;

  // Count rising edges of the synchronised pulse
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fanSync_r <= 3'h0;
      fanCount_r <= 8'h00;
    end else if (ce) begin
      fanSync_r <= {fanSync_r[1:0], fanSpeedPulse};
      if (fanSync_r[1] && !fanSync_r[2]) begin
        fanCount_r <= fanCount_r + 8'h01;
      end
    end
  end

endmodule // limit_status_alert_monitor

//--- sim/lsam_monitor.sv
// Concurrent checks on the limit monitor's ports
`timescale 1ns/100ps

module lsam_monitor #(
  parameter int unsigned LOCAL_SLOT_CYC = 40
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic linkClk,
  input wire logic linkReset_n,
  input wire logic linkReq,
  input wire logic linkAra,
  input wire logic linkAck,
  input wire logic linkBusy,
  input wire logic convStart,
  input wire logic convRemote,
  input wire logic convDone,
  input wire logic overtempSignal,
  input wire logic alertOut,
  input wire logic alertOe
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  // Cycles since the last slot start
  logic [31:0] sinceStart_r;
  logic [31:0] sinceStart_nxt;
  assign sinceStart_nxt = convStart ? 32'h0 : sinceStart_r + 32'h1;
  // Counter clears at each slot start
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sinceStart_r <= 32'h0;
    end else begin
      sinceStart_r <= sinceStart_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Core domain
  // ----------------------------------------------------------------
  chk_alert_pin_low: assert property (@(posedge clk) disable iff (!reset_n)
    alertOut == 1'b0) else $error("alert data not low");
  chk_start_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    convStart |=> !convStart) else $error("slot start longer than one cycle");
  chk_remote_start: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(convRemote) |-> ##[0:2] convStart) else $error("remote slot without start");
  chk_local_slot: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(convRemote) |-> (sinceStart_r + 32'd3 >= LOCAL_SLOT_CYC) && (sinceStart_r <= LOCAL_SLOT_CYC + 32'd2))
    else $error("local slot length wrong");
  chk_boot_start: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> ##[1:2] convStart) else $error("no slot start after reset");
  chk_overtemp_cause: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(overtempSignal) |-> $past(convDone, 2)) else $error("overtemp moved without a result");

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  chk_ack_pulse: assert property (@(posedge linkClk) disable iff (!linkReset_n)
    linkAck |=> !linkAck) else $error("ack longer than one cycle");
  chk_ack_frees: assert property (@(posedge linkClk) disable iff (!linkReset_n)
    linkAck |-> !linkBusy) else $error("busy still high at ack");
  chk_take_busy: assert property (@(posedge linkClk) disable iff (!linkReset_n)
    (linkReq || linkAra) && !linkBusy |=> linkBusy [*2]) else $error("request not taken");
  chk_busy_bound: assert property (@(posedge linkClk) disable iff (!linkReset_n)
    linkBusy |-> ##[0:80] linkAck) else $error("request never answered");

  // Main scenarios reached
  cover property (@(posedge clk) disable iff (!reset_n) $rose(alertOe));
  cover property (@(posedge clk) disable iff (!reset_n) $fell(alertOe));
  cover property (@(posedge linkClk) disable iff (!linkReset_n) linkAra && !linkBusy);
endmodule // lsam_monitor

//--- sim/lsam_host_model.sv
// Register host model driving the link request port
`timescale 1ns/100ps

module lsam_host_model (
  input wire logic linkClk,
  input wire logic linkAck,
  output logic linkReq,
  output logic linkWrite,
  output logic linkAra,
  output logic [7:0] linkAddr,
  output logic [7:0] linkWdata
);
  // Expected answers; bit 8 marks a read to compare
  logic [8:0] expQ[$];

  // Idle lines at time zero
  initial begin
    linkReq = 1'b0;
    linkWrite = 1'b0;
    linkAra = 1'b0;
    linkAddr = 8'h00;
    linkWdata = 8'h00;
  end

  // One request: strobe and qualifiers held until the answer
  task automatic xfer(input logic wr, input logic ara, input logic [7:0] addr, input logic [7:0] data,
                      input logic [8:0] exp);
    int n;
    n = 0;
    @(negedge linkClk);
    expQ.push_back(exp);
    linkWrite = wr;
    linkAra = ara;
    linkReq = !ara;
    linkAddr = addr;
    linkWdata = data;
    @(negedge linkClk);
    // Bounded wait for the answer
    while (linkAck !== 1'b1 && n < 200) begin
      @(negedge linkClk);
      n++;
    end
    // Released address and data lines show the inverse, never a stale value
    linkReq = 1'b0;
    linkAra = 1'b0;
    linkAddr = ~addr;
    linkWdata = ~data;
  endtask
endmodule // lsam_host_model

//--- sim/limit_status_alert_monitor_tb_top.sv
// Self-checking bench of the limit, status and alert monitor
`timescale 1ns/100ps

module limit_status_alert_monitor_tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic linkClk = 1'b0;
  logic reset_n = 1'b0;
  logic linkReset_n = 1'b0;
  logic convDone = 1'b0;
  logic [7:0] convData = 8'h00;
  logic fanSpeedPulse = 1'b0;
  logic [7:0] locVal = 8'h60; // Local result to hand back
  logic [7:0] remVal = 8'h60; // Remote result to hand back
  logic linkReq, linkWrite, linkAra, linkAck, linkBusy, convStart, convRemote, overtempSignal, alertOut, alertOe;
  logic [7:0] linkAddr, linkWdata, linkRdata, fanPulseCount, rnd;
  logic [8:0] exp9;
  int errorCnt = 0;
  int testsRun = 0;
  int startCnt = 0;
  int nFan;
  // Offsets and their reset values, one unmapped
  logic [7:0] rstAddr[15] = '{8'h01, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h19,
                              8'h30, 8'h4f, 8'h50, 8'h51};
  logic [7:0] rstVal[15] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h8b, 8'h54, 8'h95, 8'h8b, 8'h54, 8'h95, 8'hff,
                             8'h00, 8'h00, 8'h00, 8'h00};

  // Clocks with unrelated phase
  always #12.5 clk = ~clk;
  always #3 linkClk = ~linkClk;

  limit_status_alert_monitor #(.LOCAL_SLOT_CYC(40), .REMOTE_SLOT_CYC(80), .FAST_SLOT_CYC(20)) dut (
    .clk(clk), .reset_n(reset_n), .ce(1'b1), .linkClk(linkClk), .linkReset_n(linkReset_n),
    .linkReq(linkReq), .linkWrite(linkWrite), .linkAra(linkAra), .linkAddr(linkAddr), .linkWdata(linkWdata),
    .linkRdata(linkRdata), .linkAck(linkAck), .linkBusy(linkBusy), .convStart(convStart),
    .convRemote(convRemote), .convDone(convDone), .convData(convData), .convFault(1'b0),
    .fanSpeedPulse(fanSpeedPulse), .fanPulseCount(fanPulseCount), .overtempSignal(overtempSignal),
    .alertOut(alertOut), .alertOe(alertOe));

  lsam_host_model host (.linkClk(linkClk), .linkAck(linkAck), .linkReq(linkReq), .linkWrite(linkWrite),
    .linkAra(linkAra), .linkAddr(linkAddr), .linkWdata(linkWdata));

  // ----------------------------------------------------------------
  // Converter stand-in and slot counter
  // ----------------------------------------------------------------
  // Answers each slot start a few cycles later
  always @(negedge clk) begin
    if (convStart === 1'b1) begin
      startCnt++;
      repeat (2) @(negedge clk);
      convData = convRemote ? remVal : locVal;
      convDone = 1'b1;
      @(negedge clk);
      convDone = 1'b0;
      convData = ~convData;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errorCnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.xfer(1'b0, 1'b0, a, 8'h00, {1'b1, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, 1'b0, a, d, 9'h000);
  endtask
  // Two full local plus remote monitoring cycles
  task automatic settle();
    repeat (260) @(negedge clk);
  endtask
  task automatic done(input string name);
    $display("test %0s finished", name);
  endtask
  task automatic reportAndStop();
    if (host.expQ.size() != 0) begin
      errorCnt++;
      $display("mismatch at %0t: answers missing", $time);
    end
    $display("checks %0d mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watcher pairs each answer with the oldest note
  always @(negedge linkClk) begin
    if (linkAck === 1'b1) begin
      if (host.expQ.size() == 0) begin
        errorCnt++;
        $display("mismatch at %0t: answer without request", $time);
      end else begin
        exp9 = host.expQ.pop_front();
        if (exp9[8]) check(linkRdata, exp9[7:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h05bc));
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    linkReset_n = 1'b1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 15; i++) rd(rstAddr[i], rstVal[i]);
    done("reset_values");
    rnd = 8'($urandom());
    wr(8'h19, rnd);
    rd(8'h19, rnd);
    wr(8'h0a, ~rnd);
    rd(8'h0a, ~rnd);
    done("random_rw");
    // High limit met exactly, low limit met exactly
    locVal = 8'h8b;
    remVal = 8'h54;
    nFan = $urandom_range(8, 1);
    repeat (nFan) begin
      fanSpeedPulse = 1'b1;
      repeat (4) @(negedge clk);
      fanSpeedPulse = 1'b0;
      repeat (4) @(negedge clk);
    end
    settle();
    check(fanPulseCount, 8'(nFan));
    rd(8'h41, 8'h8b);
    rd(8'h43, 8'h54);
    rd(8'h4f, 8'h80);
    rd(8'h51, 8'h01);
    done("limits");
    // Local back inside, remote just below low
    locVal = 8'h8a;
    remVal = 8'h53;
    settle();
    rd(8'h4f, 8'h90);
    rd(8'h4f, 8'h10);
    done("sticky");
    // Mask every status one source
    wr(8'h08, 8'hff);
    repeat (4) @(negedge clk);
    check({7'h00, alertOe}, 8'h00);
    rd(8'h51, 8'h00);
    rd(8'h4f, 8'h10);
    done("mask");
    // Latched alert held, then cleared by alert response
    remVal = 8'h60;
    settle();
    wr(8'h08, 8'h00);
    repeat (4) @(negedge clk);
    check({7'h00, alertOe}, 8'h01);
    host.xfer(1'b0, 1'b1, 8'h00, 8'h00, 9'h000);
    repeat (4) @(negedge clk);
    check({7'h00, alertOe}, 8'h00);
    rd(8'h4f, 8'h00);
    done("alert_response");
    // Comparator alert and overtemp
    wr(8'h01, 8'h09);
    locVal = 8'h95;
    remVal = 8'h53;
    settle();
    check({6'h00, overtempSignal, alertOe}, 8'h03);
    rd(8'h50, 8'h80);
    locVal = 8'h60;
    remVal = 8'h60;
    settle();
    check({6'h00, overtempSignal, alertOe}, 8'h00);
    rd(8'h50, 8'h80);
    rd(8'h50, 8'h00);
    done("comparator");
    // Stop and restart monitoring
    wr(8'h01, 8'h00);
    startCnt = 0;
    repeat (300) @(negedge clk);
    check(8'(startCnt), 8'h00);
    wr(8'h01, 8'h01);
    repeat (8) @(negedge clk);
    check(8'(startCnt), 8'h01);
    done("standby");
    reportAndStop();
  end

  // Watchdog, far beyond the expected run of about 50 us
  initial begin
    #500000;
    errorCnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    reportAndStop();
  end
endmodule // limit_status_alert_monitor_tb_top

bind limit_status_alert_monitor lsam_monitor #(.LOCAL_SLOT_CYC(LOCAL_SLOT_CYC)) monitor (
  .clk(clk), .reset_n(reset_n), .linkClk(linkClk), .linkReset_n(linkReset_n), .linkReq(linkReq),
  .linkAra(linkAra), .linkAck(linkAck), .linkBusy(linkBusy), .convStart(convStart), .convRemote(convRemote),
  .convDone(convDone), .overtempSignal(overtempSignal), .alertOut(alertOut), .alertOe(alertOe));
